/* File: verilog/sxr_pkg.sv */
// constants of the serial transmit/receive control and receive status block
// Summary of operation
// - tx_buf_empty bit 1 shows transmit buffer empty
// - rx_full bit 3 shows received data held
// - irq source: buffer empty or shifter empty
// - bit 5 enables continuous receive mode
// - data_invert bit 6 inverts serial data
// - inversion acts only in modes 001,100,101
// - bit 7 enables the error signal output
// - rx data in bits 7..0, undefined after reset
// - ninth received bit or ID flag at bit 8
// - overrun_flag at bit 12
// - framing bit 13, parity bit 14
// - any_error_flag bit 15 ors three flags
// - mode 000 or receiver off clears errors
// - low byte read clears parity and framing
// - sync and two-wire modes disable error flags
// - bits 9,10 undefined; bit 11 written 0
// - tx_shift_empty shows shifter idle
package sxr_pkg;
  localparam logic [7:0] SXR_IDX_MODE = 8'hA8;
  localparam logic [7:0] SXR_IDX_STAT = 8'hA9;
  localparam logic [7:0] SXR_IDX_TXBUF = 8'hAA;
  localparam logic [7:0] SXR_IDX_CTL = 8'hAD;
  localparam logic [7:0] SXR_IDX_RXBUF = 8'hAE;
  localparam int SXR_B_TX_ON = 0;
  localparam int SXR_B_TX_EMPTY = 1;
  localparam int SXR_B_RX_ON = 2;
  localparam int SXR_B_RX_FULL = 3;
  localparam int SXR_B_IRQ_SEL = 4;
  localparam int SXR_B_CONT_RX = 5;
  localparam int SXR_B_INVERT = 6;
  localparam int SXR_B_ERR_OUT = 7;
  localparam int SXR_B_ID = 8;
  localparam int SXR_B_RESV = 11;
  localparam int SXR_B_OVR = 12;
  localparam int SXR_B_FER = 13;
  localparam int SXR_B_PER = 14;
  localparam int SXR_B_SUM = 15;
  localparam int SXR_B_SHIFT_EMPTY = 0;
  localparam logic [2:0] SXR_MODE_OFF = 3'h0;
  localparam logic [2:0] SXR_MODE_SYNC = 3'h1;
  localparam logic [2:0] SXR_MODE_TWOWIRE = 3'h2;
  localparam logic [2:0] SXR_MODE_ASYNC7 = 3'h4;
  localparam logic [2:0] SXR_MODE_ASYNC8 = 3'h5;
  localparam logic [2:0] SXR_MODE_ASYNC9 = 3'h6;
  localparam logic [7:0] SXR_CTL_RESET = 8'h02;
  localparam logic [2:0] SXR_MODE_RESET = 3'h0;
  localparam logic SXR_LINE_IDLE = 1'h1;
endpackage : sxr_pkg

/* File: verilog/sxr_flag.sv */
// sticky status flag, a set in the clearing cycle wins
`timescale 1ns/1ps
module sxr_flag (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic q_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= 1'b0;
    end else if (set_i) begin
      q_o <= 1'b1;
    end else if (clr_i) begin
      q_o <= 1'b0;
    end
  end
endmodule : sxr_flag

/* File: verilog/sxr_sync.sv */
// two-flop synchroniser for a pin level
`timescale 1ns/1ps
module sxr_sync
  import sxr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= SXR_LINE_IDLE;
      q_o <= SXR_LINE_IDLE;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : sxr_sync

/* File: verilog/sxr_ctl.sv */
// serial channel control register, transmit buffer and receive buffer with error flags
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
module sxr_ctl
  import sxr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [8:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_take_i,
  input wire logic tx_shift_busy_i,
  input wire logic tx_ser_i,
  output logic txd_o,
  input wire logic rxd_i,
  output logic rx_ser_o,
  input wire logic rx_done_i,
  input wire logic [8:0] rx_data_i,
  input wire logic rx_fer_i,
  input wire logic rx_per_i,
  output logic tx_on_o,
  output logic rx_on_o,
  output logic [2:0] mode_o,
  output logic cont_rx_o,
  output logic tx_irq_o,
  output logic err_sig_n_o,
  output logic err_oe_o
);
  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic [7:0] idx;
  logic req;
  logic wr_fire;
  logic rd_fire;
  logic rd_rx_lo;
  logic [31:0] next_rdata;

  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i && wb_stb_i;
  // writes and read side effects happen at the edge where the master sees ack
  assign wr_fire = req && wb_we_i && wb_ack_o;
  assign rd_fire = req && !wb_we_i && wb_ack_o;
  assign rd_rx_lo = rd_fire && (idx == SXR_IDX_RXBUF) && wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // control register
  logic tx_on;
  logic rx_on;
  logic irq_sel;
  logic cont_rx;
  logic invert;
  logic err_out_en;
  logic [2:0] mode;
  logic resv;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_on <= SXR_CTL_RESET[SXR_B_TX_ON];
      rx_on <= SXR_CTL_RESET[SXR_B_RX_ON];
      irq_sel <= SXR_CTL_RESET[SXR_B_IRQ_SEL];
      cont_rx <= SXR_CTL_RESET[SXR_B_CONT_RX];
      invert <= SXR_CTL_RESET[SXR_B_INVERT];
      err_out_en <= SXR_CTL_RESET[SXR_B_ERR_OUT];
    end else if (wr_fire && idx == SXR_IDX_CTL && wb_sel_i[0]) begin
      tx_on <= wb_dat_i[SXR_B_TX_ON];
      rx_on <= wb_dat_i[SXR_B_RX_ON];
      irq_sel <= wb_dat_i[SXR_B_IRQ_SEL];
      cont_rx <= wb_dat_i[SXR_B_CONT_RX];
      invert <= wb_dat_i[SXR_B_INVERT];
      err_out_en <= wb_dat_i[SXR_B_ERR_OUT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= SXR_MODE_RESET;
    end else if (wr_fire && idx == SXR_IDX_MODE && wb_sel_i[0]) begin
      mode <= wb_dat_i[2:0];
    end
  end

  // reserved bit is kept so software can read back what it wrote
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resv <= 1'b0;
    end else if (wr_fire && idx == SXR_IDX_RXBUF && wb_sel_i[1]) begin
      resv <= wb_dat_i[SXR_B_RESV];
    end
  end

  assign tx_on_o = tx_on;
  assign rx_on_o = rx_on;
  assign mode_o = mode;
  assign cont_rx_o = cont_rx;
  assign err_oe_o = err_out_en;

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer
  logic tx_buf_empty;
  logic tx_shift_empty;
  logic tx_load;

  assign tx_load = wr_fire && idx == SXR_IDX_TXBUF && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_data_o <= 9'h000;
    end else if (tx_load) begin
      tx_data_o <= {wb_sel_i[1] ? wb_dat_i[SXR_B_ID] : tx_data_o[8], wb_dat_i[7:0]};
    end
  end

  // a load in the cycle the shifter takes the old word keeps the buffer full
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_buf_empty <= SXR_CTL_RESET[SXR_B_TX_EMPTY];
    end else if (tx_load) begin
      tx_buf_empty <= 1'b0;
    end else if (tx_take_i && tx_valid_o) begin
      tx_buf_empty <= 1'b1;
    end
  end

  assign tx_valid_o = tx_on && !tx_buf_empty;
  assign tx_shift_empty = !tx_shift_busy_i;
  assign tx_irq_o = irq_sel ? tx_shift_empty : tx_buf_empty;

  ////////////////////////////////////////////////////////////////////////////
  // line polarity
  logic inv_eff;
  logic rxd_s;

  sxr_sync u_rxd_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(rxd_i),
    .q_o(rxd_s)
  );

  // two-wire and 9-bit modes never invert, whatever software left in the bit
  assign inv_eff = invert && (mode == SXR_MODE_SYNC || mode == SXR_MODE_ASYNC7
                              || mode == SXR_MODE_ASYNC8);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txd_o <= SXR_LINE_IDLE;
      rx_ser_o <= SXR_LINE_IDLE;
    end else begin
      txd_o <= tx_ser_i ^ inv_eff;
      rx_ser_o <= rxd_s ^ inv_eff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive buffer and error flags
  logic rx_full;
  logic [8:0] rx_data;
  logic err_ok;
  logic err_clr;
  logic ovr;
  logic framing_flag;
  logic parity_flag;
  logic any_err;

  // data has no reset: it reads undefined until the first frame
  always_ff @(posedge clk_i) begin
    if (rx_done_i) begin
      rx_data <= rx_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_full <= SXR_CTL_RESET[SXR_B_RX_FULL];
    end else if (rx_done_i) begin
      rx_full <= 1'b1;
    end else if (rd_rx_lo || !rx_on) begin
      rx_full <= 1'b0;
    end
  end

  // flags live only in asynchronous modes with the receiver on
  assign err_ok = rx_on && mode[2];
  // sync and two-wire modes hold the flags cleared so they read 0
  assign err_clr = (mode == SXR_MODE_OFF) || !rx_on || !mode[2];

  sxr_flag u_ovr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(err_ok && rx_done_i && rx_full && !rd_rx_lo),
    .clr_i(err_clr),
    .q_o(ovr)
  );

  sxr_flag u_fer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(err_ok && rx_done_i && rx_fer_i),
    .clr_i(err_clr || rd_rx_lo),
    .q_o(framing_flag)
  );

  sxr_flag u_per (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(err_ok && rx_done_i && rx_per_i),
    .clr_i(err_clr || rd_rx_lo),
    .q_o(parity_flag)
  );

  assign any_err = ovr || framing_flag || parity_flag;

  // error signal is an active-low pulse on the line after a parity fault
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_sig_n_o <= 1'b1;
    end else begin
      err_sig_n_o <= !(err_out_en && err_ok && rx_done_i && rx_per_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and ack
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (idx)
      SXR_IDX_CTL: begin
        next_rdata[SXR_B_TX_ON] = tx_on;
        next_rdata[SXR_B_TX_EMPTY] = tx_buf_empty;
        next_rdata[SXR_B_RX_ON] = rx_on;
        next_rdata[SXR_B_RX_FULL] = rx_full;
        next_rdata[SXR_B_IRQ_SEL] = irq_sel;
        next_rdata[SXR_B_CONT_RX] = cont_rx;
        next_rdata[SXR_B_INVERT] = invert;
        next_rdata[SXR_B_ERR_OUT] = err_out_en;
      end
      SXR_IDX_RXBUF: begin
        next_rdata[8:0] = rx_data;
        next_rdata[SXR_B_RESV] = resv;
        next_rdata[SXR_B_OVR] = ovr;
        next_rdata[SXR_B_FER] = framing_flag;
        next_rdata[SXR_B_PER] = parity_flag;
        next_rdata[SXR_B_SUM] = any_err;
      end
      SXR_IDX_MODE: next_rdata[2:0] = mode;
      SXR_IDX_STAT: next_rdata[SXR_B_SHIFT_EMPTY] = tx_shift_empty;
      SXR_IDX_TXBUF: next_rdata[8:0] = tx_data_o;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // unmapped addresses are acked with zero data and writes dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      wb_dat_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");

  AST_TX_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_load |=> !tx_buf_empty && tx_valid_o == tx_on)
    else $error("tx buffer still empty after load");

  AST_RX_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_done_i |=> rx_full && rx_data == $past(rx_data_i))
    else $error("received word not held");

  AST_IRQ_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_sel && tx_shift_busy_i |-> !tx_irq_o)
    else $error("tx irq while shifter busy");

  AST_NO_INV: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == SXR_MODE_TWOWIRE || mode == SXR_MODE_ASYNC9) |=> txd_o == $past(tx_ser_i))
    else $error("line inverted in a mode without inversion");

  AST_OVERRUN: assert property (@(posedge clk_i) disable iff (rst_i)
    err_ok && rx_done_i && rx_full && !rd_rx_lo |=> ovr)
    else $error("overrun not flagged");

  AST_SUM: assert property (@(posedge clk_i) disable iff (rst_i)
    any_err == (ovr || framing_flag || parity_flag))
    else $error("error sum disagrees with flags");

  AST_RX_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !rx_on |=> !ovr && !framing_flag && !parity_flag)
    else $error("error flag survives receiver off");

  AST_RD_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_rx_lo && !rx_done_i |=> !framing_flag && !parity_flag)
    else $error("low byte read left parity or framing set");

  AST_SYNC_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    $stable(mode) && (mode == SXR_MODE_SYNC) && $past(mode == SXR_MODE_SYNC)
    |-> !ovr && !framing_flag && !parity_flag)
    else $error("error flag raised in synchronous mode");
endmodule : sxr_ctl

/* File: tb/sxr_far.sv */
// far-side model: transmit shifter and receive word source with done pulse of the remote station
`timescale 1ns/1ps
module sxr_far (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hold_i,
  input wire logic tx_valid_i,
  input wire logic [8:0] tx_data_i,
  input wire logic rx_go_i,
  input wire logic [8:0] rx_word_i,
  input wire logic fer_i,
  input wire logic per_i,
  output logic tx_take_o,
  output logic tx_shift_busy_o,
  output logic tx_ser_o,
  output logic rx_done_o,
  output logic [8:0] rx_data_o,
  output logic rx_fer_o,
  output logic rx_per_o
);
  logic [4:0] cnt;
  logic [8:0] sh;
  ////////////////////////////////////////
  // hold_i stalls the take so the bench can see a full buffer
  always_ff @(posedge clk_i) begin
    tx_take_o <= 1'b0;
    if (rst_i) begin
      cnt <= 5'h00;
      sh <= 9'h1FF;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
      sh <= {1'b1, sh[8:1]};
    end else if (tx_valid_i && !hold_i) begin
      tx_take_o <= 1'b1;
      cnt <= 5'h14;
      sh <= tx_data_i;
    end
  end
  assign tx_shift_busy_o = (cnt != 5'h00);
  assign tx_ser_o = tx_shift_busy_o ? sh[0] : 1'b1;
  // outside the done pulse the word lines toggle, so stale data is never seen as valid
  always_ff @(posedge clk_i) begin
    rx_done_o <= rx_go_i && !rst_i;
    if (rx_go_i) begin
      rx_data_o <= rx_word_i;
      rx_fer_o <= fer_i;
      rx_per_o <= per_i;
    end else begin
      rx_data_o <= ~rx_data_o;
      rx_fer_o <= ~rx_fer_o;
      rx_per_o <= ~rx_per_o;
    end
  end
endmodule : sxr_far

/* File: tb/test_serial_txrx_control_and_rx_status.sv */
// self-checking bench of the serial control and receive status block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s expected %h seen %h", n, e, g); end end
module test_serial_txrx_control_and_rx_status import sxr_pkg::*;;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, hold = 1, go = 0, framing_flag = 0, parity_flag = 0;
  logic rxd = 1, lowseen;
  logic [9:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0, q, dat_o;
  logic [8:0] word = '0, tx_data, rx_data;
  logic ack, tx_valid, take, busy, ser, done, rfer, rper, txd, rx_ser;
  logic tx_on, rx_on, cont, irq, errn, erroe;
  logic [2:0] mode;
  int failures = 0, comparisons = 0;
  ////////////////////////////////////////
  sxr_ctl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_take_i(take), .tx_shift_busy_i(busy),
    .tx_ser_i(ser), .txd_o(txd), .rxd_i(rxd), .rx_ser_o(rx_ser), .rx_done_i(done),
    .rx_data_i(rx_data), .rx_fer_i(rfer), .rx_per_i(rper), .tx_on_o(tx_on), .rx_on_o(rx_on),
    .mode_o(mode), .cont_rx_o(cont), .tx_irq_o(irq), .err_sig_n_o(errn), .err_oe_o(erroe));
  sxr_far far (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .rx_go_i(go), .rx_word_i(word), .fer_i(framing_flag), .per_i(parity_flag),
    .tx_take_o(take), .tx_shift_busy_o(busy), .tx_ser_o(ser), .rx_done_o(done),
    .rx_data_o(rx_data), .rx_fer_o(rfer), .rx_per_o(rper));
  initial forever #25 clk_i = ~clk_i;
  ////////////////////////////////////////
  task summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= {idx, 2'h0}; sel <= 4'h3; wdat <= d;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 0; stb <= 0;
    if (ack !== 1'b1) begin failures++; summarize(); end
  endtask : bus
  task rd(input logic [7:0] idx); bus(0, idx, 32'h0); endtask : rd
  task wr(input logic [7:0] idx, input logic [31:0] d); bus(1, idx, d); endtask : wr
  task rxw(input logic [8:0] w, input logic f, input logic p);
    @(posedge clk_i); go <= 1; word <= w; framing_flag <= f; parity_flag <= p;
    @(posedge clk_i); go <= 0;
    lowseen = 0;
    repeat (4) begin @(posedge clk_i); if (errn === 1'b0) lowseen = 1; end
  endtask : rxw
  ////////////////////////////////////////
  task t_reset;
    rd(SXR_IDX_CTL); `CHK("ctl", SXR_CTL_RESET, q[7:0])
    `CHK("irq", 1'b1, irq)
    rd(8'h10); `CHK("unmapped", 32'h0, q)
  endtask : t_reset
  task t_tx;
    wr(SXR_IDX_MODE, 32'h5); wr(SXR_IDX_CTL, 32'h05); wr(SXR_IDX_TXBUF, 32'h155);
    rd(SXR_IDX_CTL); `CHK("ctl full", 8'h05, q[7:0])
    `CHK("tx valid", 1'b1, tx_valid)
    `CHK("irq full", 1'b0, irq)
    `CHK("tx word", 9'h155, tx_data)
    `CHK("txd plain", 1'b1, txd)
    hold <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(SXR_IDX_CTL); `CHK("ctl empty", 8'h07, q[7:0])
    `CHK("irq empty", 1'b1, irq)
    wr(SXR_IDX_CTL, 32'h15);
    @(posedge clk_i);
    `CHK("irq shifting", 1'b0, irq)
    rd(SXR_IDX_STAT); `CHK("shift busy", 1'b0, q[0])
    repeat (25) @(posedge clk_i);
    rd(SXR_IDX_STAT); `CHK("shift idle", 1'b1, q[0])
    `CHK("irq done", 1'b1, irq)
  endtask : t_tx
  task t_rx;
    wr(SXR_IDX_CTL, 32'h84); rxw(9'h1A5, 1, 0);
    rd(SXR_IDX_CTL); `CHK("rx full", 8'h8E, q[7:0])
    rd(SXR_IDX_RXBUF); `CHK("rx fer", 16'hA1A5, q[15:0])
    rd(SXR_IDX_RXBUF); `CHK("rx fer clr", 16'h01A5, q[15:0])
    rxw(9'h03C, 0, 1); `CHK("err pulse", 1'b1, lowseen)
    `CHK("err oe", 1'b1, erroe)
    rd(SXR_IDX_RXBUF); `CHK("rx per", 16'hC03C, q[15:0])
    rxw(9'h011, 0, 0); rxw(9'h022, 0, 0);
    rd(SXR_IDX_RXBUF); `CHK("overrun", 16'h9022, q[15:0])
    rd(SXR_IDX_RXBUF); `CHK("overrun kept", 16'h9022, q[15:0])
    wr(SXR_IDX_CTL, 32'h80);
    rd(SXR_IDX_RXBUF); `CHK("rx off clr", 4'h0, q[15:12])
    wr(SXR_IDX_MODE, 32'h1); wr(SXR_IDX_CTL, 32'h84); rxw(9'h0FF, 1, 1);
    rd(SXR_IDX_RXBUF); `CHK("sync flags", 4'h0, q[15:12])
  endtask : t_rx
  task t_inv;
    wr(SXR_IDX_CTL, 32'h64); repeat (4) @(posedge clk_i);
    `CHK("cont rx", 1'b1, cont)
    `CHK("rx on", 1'b1, rx_on)
    `CHK("tx on", 1'b0, tx_on)
    `CHK("mode", SXR_MODE_SYNC, mode)
    `CHK("txd inv", 1'b0, txd)
    `CHK("rx inv", 1'b0, rx_ser)
    rxd <= 1'b0; repeat (4) @(posedge clk_i);
    `CHK("rx inv low", 1'b1, rx_ser)
    rxd <= 1'b1;
    wr(SXR_IDX_CTL, 32'h40); wr(SXR_IDX_MODE, 32'h0); repeat (4) @(posedge clk_i);
    `CHK("txd off", 1'b1, txd)
    wr(SXR_IDX_MODE, 32'h4); repeat (4) @(posedge clk_i);
    `CHK("txd async7", 1'b0, txd)
    wr(SXR_IDX_CTL, 32'h00);
    wr(SXR_IDX_MODE, 32'h6); repeat (4) @(posedge clk_i);
    `CHK("txd async9", 1'b1, txd)
    wr(SXR_IDX_MODE, 32'h2); repeat (4) @(posedge clk_i);
    `CHK("txd twowire", 1'b1, txd)
  endtask : t_inv
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset(); t_tx(); t_rx(); t_inv();
    summarize();
  end
endmodule : test_serial_txrx_control_and_rx_status
